//--- src/ledl_map.svh
`ifndef LEDL_MAP_SVH
`define LEDL_MAP_SVH
// Clock and oscillator rates in kHz
`define LEDL_CLK_KHZ 100000
`define LEDL_OSC_KHZ 450
// Scan tick divider, rounded down
`define LEDL_OSC_DIV (`LEDL_CLK_KHZ / `LEDL_OSC_KHZ)
// Scan ticks per grid slot
`define LEDL_SLOT_TICKS 16
// Command class in bits 7..6
`define LEDL_CLS_DATA 2'h1
`define LEDL_CLS_DISP 2'h2
`define LEDL_CLS_ADDR 2'h3
// Command field positions
`define LEDL_BIT_FIXED 2
`define LEDL_BIT_TEST 3
`define LEDL_BIT_ON 3
// Host serial half period in ns
`define LEDL_HALF_NS 500
`define LEDL_HALF_CYC ((`LEDL_HALF_NS * `LEDL_CLK_KHZ + 999999) / 1000000)
// Host register offsets
`define LEDL_REG_TX 4'h0
`define LEDL_REG_STAT 4'h4
// Host transmit word fields
`define LEDL_TX_START 8
`define LEDL_TX_END 9
`endif

//--- src/ledl_pkg.sv
package ledl_pkg;
  // Host serial sequencer states
  typedef enum logic [2:0] {
    HS_IDLE, HS_PRE, HS_CLKHI, HS_STDN, HS_BLO, HS_BHI, HS_ELO, HS_EHI
  } ledl_hst_e;
  typedef logic [7:0] ledl_byte_t;
endpackage

//--- src/ledl_if.sv
`timescale 1ns/10ps
interface ledl_if;
  // Serial clock from host
  logic sclk;
  // Serial data from host
  logic din;
  // One-hot active grid, high sinks the common
  logic [15:0] digit_common_outputs;
  // Lit segments, high sources the anode
  logic [7:0] segment_outputs;
  modport dev (input sclk, input din, output digit_common_outputs, output segment_outputs);
  modport host (output sclk, output din, input digit_common_outputs, input segment_outputs);
endinterface

//--- src/ledl_host.sv
`timescale 1ns/10ps
`include "ledl_map.svh"
module ledl_host (
  input wire logic ref_clk,
  input wire logic rst,
  ledl_if.host lnk,
  input wire logic [3:0] addr,
  input wire logic [9:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [9:0] rdata
);
  // Whole host state
  typedef struct packed {
    ledl_pkg::ledl_hst_e st;
    logic [7:0] tmr;
    logic [9:0] tx;
    logic [2:0] bitn;
    logic sclk;
    logic din;
    logic [9:0] rdata;
  } ledl_hs_s;
  ledl_hs_s s_reg;
  ledl_hs_s s_next;
  // Sequencer step strobe
  logic step;
  assign step = (s_reg.tmr == 8'h00);
  assign lnk.sclk = s_reg.sclk;
  assign lnk.din = s_reg.din;
  assign rdata = s_reg.rdata;

  // Next state
  always_comb
  begin
    s_next = s_reg;
    // Half period timer
    s_next.tmr = step ? 8'((`LEDL_HALF_CYC) - 1) : s_reg.tmr - 8'h01;
    // Read data one cycle later
    s_next.rdata = 10'h000;
    if (rd)
    begin
      if (addr == `LEDL_REG_TX)
        s_next.rdata = s_reg.tx;
      else if (addr == `LEDL_REG_STAT)
        s_next.rdata = {9'h000, s_reg.st != ledl_pkg::HS_IDLE};
    end
    // Accept a byte only while idle
    if (wr && addr == `LEDL_REG_TX && s_reg.st == ledl_pkg::HS_IDLE)
    begin
      s_next.tx = wdata;
      s_next.bitn = 3'h0;
      s_next.tmr = 8'((`LEDL_HALF_CYC) - 1);
      s_next.st = wdata[`LEDL_TX_START] ? ledl_pkg::HS_PRE : ledl_pkg::HS_BLO;
    end
    else if (step)
    begin
      unique case (s_reg.st)
        // Nothing to send
        ledl_pkg::HS_IDLE:
        begin
          s_next.st = ledl_pkg::HS_IDLE;
        end
        // RULE_05 - Start: data high
        ledl_pkg::HS_PRE:
        begin
          s_next.din = 1'b1;
          s_next.st = ledl_pkg::HS_CLKHI;
        end
        // Clock high before start edge
        ledl_pkg::HS_CLKHI:
        begin
          s_next.sclk = 1'b1;
          s_next.st = ledl_pkg::HS_STDN;
        end
        // RULE_05 - Data falls, clock high
        ledl_pkg::HS_STDN:
        begin
          s_next.din = 1'b0;
          s_next.st = ledl_pkg::HS_BLO;
        end
        // RULE_02 - Change data while low
        ledl_pkg::HS_BLO:
        begin
          s_next.sclk = 1'b0;
          // RULE_03 - Least bit first
          s_next.din = s_reg.tx[s_reg.bitn];
          s_next.st = ledl_pkg::HS_BHI;
        end
        // RULE_01 - Data steady while high
        ledl_pkg::HS_BHI:
        begin
          s_next.sclk = 1'b1;
          s_next.bitn = s_reg.bitn + 3'h1;
          if (s_reg.bitn != 3'h7)
            s_next.st = ledl_pkg::HS_BLO;
          else if (s_reg.tx[`LEDL_TX_END])
            s_next.st = ledl_pkg::HS_ELO;
          else
            s_next.st = ledl_pkg::HS_IDLE;
        end
        // Data low under low clock
        ledl_pkg::HS_ELO:
        begin
          s_next.sclk = 1'b0;
          s_next.din = 1'b0;
          s_next.st = ledl_pkg::HS_EHI;
        end
        // RULE_04 - Clock high then data rises
        ledl_pkg::HS_EHI:
        begin
          if (!s_reg.sclk)
            s_next.sclk = 1'b1;
          else
          begin
            s_next.din = 1'b1;
            s_next.st = ledl_pkg::HS_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.sclk <= 1'b1;
      s_reg.din <= 1'b1;
    end
    else
      s_reg <= s_next;
  end
endmodule

//--- src/ledl_dev.sv
`timescale 1ns/10ps
`include "ledl_map.svh"
// Operation
// RULE_01 - Host keeps data stable while clock high
// RULE_02 - Host changes data only while clock low
// RULE_03 - Bytes travel least significant bit first
// RULE_04 - Data rising under high clock ends
// RULE_05 - Data falling under high clock starts
// RULE_06 - First byte after start is command
// RULE_07 - Top two bits classify the command
// RULE_08 - End mid-byte discards the partial byte
// RULE_09 - Auto mode writes then increments address
// RULE_10 - Fixed mode writes at set address
// RULE_11 - Data-mode bit 3 selects test mode
// RULE_12 - Address command loads low four bits
// RULE_13 - Pointer starts at address zero
// RULE_14 - Byte n drives grid n+1 segments
// RULE_15 - Three bits pick eight pulse widths
// RULE_16 - Display switch blanks without touching memory (test mode still drives the outputs while switched off)
// RULE_17 - Control bit 3 set means on
// RULE_18 - Scan timed by internal oscillator
// RULE_19 - Sixteen grids scanned one at a time
// RULE_20 - Host sends mode, address, data, control
// RULE_21 - Reset clears receiver and control state
// RULE_22 - Segments blank at each grid change
module ledl_dev (
  input wire logic ref_clk,
  input wire logic rst,
  ledl_if.dev lnk
);
  // Whole device state
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic din_s1;
    logic din_s2;
    logic din_s3;
    logic in_frame;
    logic first_byte;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic fixed_addr;
    logic test_mode;
    logic [3:0] addr;
    logic disp_on;
    logic [2:0] bright;
    logic [7:0] osc_cnt;
    logic [3:0] phase;
    logic [3:0] grid;
    logic [15:0] grid_out;
    logic [7:0] seg_out;
    logic [15:0][7:0] mem;
  } ledl_ds_s;
  ledl_ds_s s_reg;
  ledl_ds_s s_next;

  // Lit phases in a sixteen phase slot
  function automatic logic [3:0] width_of(input logic [2:0] code);
    unique case (code)
      3'h0: width_of = 4'h1;
      3'h1: width_of = 4'h2;
      3'h2: width_of = 4'h4;
      3'h3: width_of = 4'ha;
      3'h4: width_of = 4'hb;
      3'h5: width_of = 4'hc;
      3'h6: width_of = 4'hd;
      3'h7: width_of = 4'he;
    endcase
  endfunction

  // Edge and condition strobes from synced pins
  logic clk_rise;
  logic start_cond;
  logic end_cond;
  logic osc_tick;
  logic [7:0] byte_in;
  logic [4:0] slot;
  assign clk_rise = s_reg.sclk_s2 && !s_reg.sclk_s3;
  // RULE_05 - Falling data under high clock
  assign start_cond = s_reg.sclk_s2 && s_reg.sclk_s3 && s_reg.din_s3 && !s_reg.din_s2;
  // RULE_04 - Rising data under high clock
  assign end_cond = s_reg.sclk_s2 && s_reg.sclk_s3 && !s_reg.din_s3 && s_reg.din_s2;
  // RULE_03 - New bit enters at the top
  assign byte_in = {s_reg.din_s2, s_reg.shreg[7:1]};
  assign osc_tick = (s_reg.osc_cnt == 8'h00);
  assign slot = 5'(`LEDL_SLOT_TICKS - 1);
  assign lnk.digit_common_outputs = s_reg.grid_out;
  assign lnk.segment_outputs = s_reg.seg_out;

  // Next state
  always_comb
  begin
    s_next = s_reg;
    // Two flip-flop pin synchronisers
    s_next.sclk_s1 = lnk.sclk;
    s_next.sclk_s2 = s_reg.sclk_s1;
    s_next.sclk_s3 = s_reg.sclk_s2;
    s_next.din_s1 = lnk.din;
    s_next.din_s2 = s_reg.din_s1;
    s_next.din_s3 = s_reg.din_s2;
    if (start_cond)
    begin
      // RULE_06 - Next byte is a command
      s_next.in_frame = 1'b1;
      s_next.first_byte = 1'b1;
      s_next.bitcnt = 4'h0;
    end
    else if (end_cond)
    begin
      // RULE_08 - Drop any partial byte
      s_next.in_frame = 1'b0;
      s_next.bitcnt = 4'h0;
    end
    else if (clk_rise && s_reg.in_frame)
    begin
      // RULE_02 - Sample bit at clock rise
      s_next.shreg = byte_in;
      s_next.bitcnt = s_reg.bitcnt + 4'h1;
      if (s_reg.bitcnt == 4'h7)
      begin
        s_next.bitcnt = 4'h0;
        s_next.first_byte = 1'b0;
        if (s_reg.first_byte)
        begin
          // RULE_07 - Classify by top two bits
          unique case (byte_in[7:6])
            // RULE_11 - Mode and test bits
            `LEDL_CLS_DATA:
            begin
              s_next.fixed_addr = byte_in[`LEDL_BIT_FIXED];
              s_next.test_mode = byte_in[`LEDL_BIT_TEST];
            end
            // RULE_15 - Brightness code
            `LEDL_CLS_DISP:
            begin
              s_next.bright = byte_in[2:0];
              // RULE_17 - Set means on
              s_next.disp_on = byte_in[`LEDL_BIT_ON];
            end
            // RULE_12 - Pointer from low nibble
            `LEDL_CLS_ADDR:
            begin
              s_next.addr = byte_in[3:0];
            end
            // Undefined class ignored
            default:
            begin
              s_next.addr = s_reg.addr;
            end
          endcase
        end
        else
        begin
          // RULE_10 - Write at current pointer
          s_next.mem[s_reg.addr] = byte_in;
          // RULE_09 - Advance in auto mode
          if (!s_reg.fixed_addr)
            s_next.addr = s_reg.addr + 4'h1;
        end
      end
    end
    // RULE_18 - Oscillator tick divider
    s_next.osc_cnt = osc_tick ? 8'((`LEDL_OSC_DIV) - 1) : s_reg.osc_cnt - 8'h01;
    if (osc_tick)
    begin
      s_next.phase = s_reg.phase + 4'h1;
      // RULE_19 - Next grid after full slot
      if ({1'b0, s_reg.phase} == slot)
        s_next.grid = s_reg.grid + 4'h1;
    end
    // Output drive
    s_next.grid_out = 16'h0000;
    s_next.seg_out = 8'h00;
    // RULE_16 - Switch off blanks outputs only, unless test mode is on
    if (s_reg.disp_on || s_reg.test_mode)
    begin
      // RULE_19 - One grid at a time
      s_next.grid_out[s_reg.grid] = 1'b1;
      // RULE_22 - First and last phase stay dark
      if (s_reg.phase != 4'h0 && s_reg.phase != 4'hf)
      begin
        // RULE_11 - Test mode lights every segment
        if (s_reg.test_mode)
          s_next.seg_out = 8'hff;
        // RULE_15 - Lit for the coded width
        else if (s_reg.phase <= width_of(s_reg.bright))
          // RULE_14 - Byte n feeds grid n+1
          s_next.seg_out = s_reg.mem[s_reg.grid];
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    // RULE_21 - Reset clears everything, pin synchronisers set high
    if (rst)
    begin
      // RULE_13 - Pointer at zero
      s_reg <= '0;
      s_reg.sclk_s1 <= 1'b1;
      s_reg.sclk_s2 <= 1'b1;
      s_reg.sclk_s3 <= 1'b1;
      s_reg.din_s1 <= 1'b1;
      s_reg.din_s2 <= 1'b1;
      s_reg.din_s3 <= 1'b1;
    end
    else
      s_reg <= s_next;
  end
endmodule

//--- test/ledl_chk.sv
`timescale 1ns/10ps
module ledl_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic [15:0] digit_common_outputs,
  input wire logic [7:0] segment_outputs
);
  // Last grid, slot age, link run length
  logic [15:0] prev_reg;
  logic [11:0] slot_reg;
  logic [11:0] run_reg;
  logic full_reg;
  logic chg;
  logic both;
  assign chg = digit_common_outputs != prev_reg;
  assign both = chg && prev_reg != 16'h0 && digit_common_outputs != 16'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Slot counter, valid once a whole slot began
  always_ff @(posedge ref_clk)
  begin
    prev_reg <= digit_common_outputs;
    slot_reg <= chg ? 12'h0 : slot_reg + 12'h1;
    full_reg <= !rst && digit_common_outputs != 16'h0 && (full_reg || both);
    run_reg <= rst ? 12'hfff : $changed(sclk) ? 12'h0 : run_reg + {11'h0, run_reg != 12'hfff};
  end
  property p_one_grid;
    $onehot0(digit_common_outputs);
  endproperty
  a_one_grid: assert property (p_one_grid) else $error("several grids on");
  property p_seg_grid;
    segment_outputs != 8'h0 |-> digit_common_outputs != 16'h0;
  endproperty
  a_seg_grid: assert property (p_seg_grid) else $error("segments without grid");
  property p_blank;
    both |-> segment_outputs == 8'h0 && $past(segment_outputs) == 8'h0;
  endproperty
  a_blank: assert property (p_blank) else $error("no blanking at changeover");
  property p_order;
    both |-> digit_common_outputs == {prev_reg[14:0], prev_reg[15]};
  endproperty
  a_order: assert property (p_order) else $error("grid out of turn");
  // Slot is 16 ticks of 222 cycles
  property p_slot;
    both && full_reg |-> slot_reg == 12'd3551;
  endproperty
  a_slot: assert property (p_slot) else $error("slot length wrong");
  property p_rst;
    disable iff (1'b0) rst |=> sclk && din && digit_common_outputs == 16'h0 && segment_outputs == 8'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_pulse;
    $changed(sclk) |-> run_reg >= 12'd39;
  endproperty
  a_pulse: assert property (p_pulse) else $error("link clock phase short");
  property p_hold;
    $rose(sclk) |=> $stable(din) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("data moved at clock high");
  cover property (both);
  cover property (sclk && $fell(din));
  cover property (segment_outputs != 8'h0);
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
`include "ledl_map.svh"
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [9:0] wdata = 10'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [9:0] rdata;
  // Bits seen at link clock rises
  logic [8:0] link_bits = 9'h0;
  // Expected display memory
  logic [7:0] mem [16];
  int wid [8] = '{1, 2, 4, 10, 11, 12, 13, 14};
  // Test mode expected, all segments lit
  logic tmode = 1'b0;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  ledl_if ledl_if_i ();
  ledl_host ledl_host_i (.ref_clk(ref_clk), .rst(rst), .lnk(ledl_if_i), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  ledl_dev ledl_dev_i (.ref_clk(ref_clk), .rst(rst), .lnk(ledl_if_i));
  ledl_chk ledl_chk_i (.ref_clk(ref_clk), .rst(rst), .sclk(ledl_if_i.sclk), .din(ledl_if_i.din),
    .digit_common_outputs(ledl_if_i.digit_common_outputs), .segment_outputs(ledl_if_i.segment_outputs));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Shift in link bits, last one on top
  always @(posedge ledl_if_i.sclk)
    link_bits <= {ledl_if_i.din, link_bits[8:1]};
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 130000)
    begin
      errors++;
      stop_test();
    end
  end
  task stop_test();
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [9:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [9:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One byte with optional start and end
  task send(input logic [7:0] b, input logic st, input logic en);
    logic [9:0] s;
    wr_reg(`LEDL_REG_TX, {en, st, b});
    rd_reg(`LEDL_REG_STAT, s);
    chk({15'h0, s[0]}, 16'h1);
    while (s[0] !== 1'b0) rd_reg(`LEDL_REG_STAT, s);
    chk({8'h0, en ? link_bits[7:0] : link_bits[8:1]}, {8'h0, b});
  endtask
  // Watch one full grid slot, or any span when dark
  task slot(input int w);
    logic [15:0] p;
    logic [7:0] v;
    int n;
    int g;
    int e;
    v = 8'h0;
    n = 0;
    g = 0;
    e = w * `LEDL_OSC_DIV;
    @(negedge ref_clk);
    p = ledl_if_i.digit_common_outputs;
    if (w != 0)
      while (ledl_if_i.digit_common_outputs === p) @(negedge ref_clk);
    p = ledl_if_i.digit_common_outputs;
    for (int i = 0; i < 16; i++)
      if (p[i] === 1'b1) g = i;
    repeat (`LEDL_SLOT_TICKS * `LEDL_OSC_DIV)
    begin
      if (ledl_if_i.segment_outputs !== 8'h0)
      begin
        n++;
        v = ledl_if_i.segment_outputs;
      end
      @(negedge ref_clk);
    end
    chk({8'h0, v}, {8'h0, w == 0 ? 8'h0 : tmode ? 8'hff : mem[g]});
    chk(n[15:0], e[15:0]);
  endtask
  initial
  begin
    logic [9:0] s;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk({14'h0, ledl_if_i.sclk, ledl_if_i.din}, 16'h3);
    rd_reg(4'h8, s);
    chk({6'h0, s}, 16'h0);
    send(8'h40, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 8'(i * 37 + 1);
      send(mem[i], 1'b0, i == 15);
    end
    send(8'h44, 1'b1, 1'b1);
    send(8'hf5, 1'b1, 1'b0);
    send(8'h11, 1'b0, 1'b0);
    send(8'h3c, 1'b0, 1'b1);
    mem[5] = 8'h3c;
    for (int c = 0; c < 8; c++)
    begin
      send(8'(8'hb8 + c), 1'b1, 1'b1);
      slot(wid[c]);
    end
    send(8'h87, 1'b1, 1'b1);
    slot(0);
    send(8'h48, 1'b1, 1'b1);
    tmode = 1'b1;
    slot(14);
    tmode = 1'b0;
    send(8'h40, 1'b1, 1'b1);
    send(8'h8f, 1'b1, 1'b1);
    slot(14);
    stop_test();
  end
endmodule
